/* File: rtl/rds_pkg.sv */
// Purpose: shared constants and carriers for the receive entry status block
// Assumes: four 16-bit words per receive ring entry
// Notes: word 1 holds the owner flag, status flags and high address bits
package rds_pkg;
  localparam int RDS_WORD_W = 16;
  localparam int RDS_ADDR_W = 24;
  localparam int RDS_CNT_W = 12;
  // word 1 field positions
  localparam int RDS_OWN_BIT = 15;
  localparam int RDS_ERR_BIT = 14;
  localparam int RDS_FRAMING_BIT = 13;
  localparam int RDS_OVERFLOW_BIT = 12;
  localparam int RDS_CRC_BIT = 11;
  localparam int RDS_BUFFER_BIT = 10;
  localparam int RDS_SOF_BIT = 9;
  localparam int RDS_EOF_BIT = 8;
  localparam int RDS_ADDR_HIGH_MSB = 7;
  // word indices inside an entry
  localparam logic [1:0] RDS_W0 = 2'h0;
  localparam logic [1:0] RDS_W1 = 2'h1;
  localparam logic [1:0] RDS_W2 = 2'h2;
  localparam logic [1:0] RDS_W3 = 2'h3;
  localparam logic [15:0] RDS_WORD_RST = 16'h0000;

  // memory request toward the system bus master
  typedef struct packed {
    logic valid;
    logic write;
    logic [1:0] word;
    logic [15:0] data;
  } rds_mreq_s;

  // end-of-buffer report from the receive datapath
  typedef struct packed {
    logic last;
    logic dribble;
    logic fcs_bad;
    logic fifo_overflow;
    logic [11:0] count;
  } rds_done_s;

  typedef enum logic [5:0] {
    RDS_IDLE = 6'h01,
    RDS_RD0 = 6'h02,
    RDS_RD1 = 6'h04,
    RDS_FILL = 6'h08,
    RDS_WR3 = 6'h10,
    RDS_WR1 = 6'h20
  } rds_state_e;
endpackage

/* File: rtl/rds_rx_entry.sv */
// Purpose: walks one receive ring entry: fetch pointer, fill, write status
// Assumes: a bus master performs o_mreq and answers with i_mack
// Notes: one entry in flight; the datapath reports each buffer's end
// Contract
// - entry is four 16-bit words
// - buffer address is word1 low byte, word0
// - any buffer alignment and length accepted
// - word1 bit 15 is owner flag
// - device clears owner after filling buffer
// - relinquished entry is never modified again
// - error bit is OR of four errors
// - framing error needs odd bits and FCS
// - framing error void in internal loopback
// - overflow flag on FIFO loss, no end
// - checksum flag on FCS mismatch
// - buffer error when next entry unowned
// - start flag in first buffer of frame
// - driver writes start flag in interrupt mode
// - end flag in last buffer
// - high address bits never altered
// - byte count in word3 bits 11-0
module rds_rx_entry
  import rds_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic i_ce,
  input wire logic i_start,
  input wire logic i_loopback,
  input wire logic i_start_of_packet_irq_mode,
  input wire logic i_mack,
  input wire logic [15:0] i_mdata,
  input wire logic i_buf_done,
  input wire rds_pkg::rds_done_s i_done,
  input wire logic i_fifo_overflow,
  output rds_pkg::rds_mreq_s o_mreq,
  output logic [23:0] o_buf_addr,
  output logic o_fill_en,
  output logic o_busy,
  output logic o_not_owned,
  output logic o_entry_done
);
  import rds_pkg::*;

  // walk state and captured entry words
  rds_state_e state_q;
  rds_state_e state_d;
  logic [15:0] word0_q;
  logic [15:0] word1_q;
  // chaining and error state
  logic in_frame_q;
  logic buffer_err_q;
  logic buffer_with_overflow_q;
  // write-back image and qualified flags
  logic [15:0] word1_wr;
  logic framing_v;
  logic overflow_v;
  logic crc_v;
  logic sof_v;
  logic word1_taken;
  rds_done_s done_q;

  // builds the 24-bit buffer address from both pointer words
  function automatic logic [23:0] buf_addr(input logic [15:0] w0, input logic [15:0] w1);
    buf_addr = {w1[RDS_ADDR_HIGH_MSB:0], w0};
  endfunction

  // owner flag of a fetched word 1: high means the controller may use the entry
  function automatic logic ctrl_owns(input logic [15:0] w1);
    ctrl_owns = w1[RDS_OWN_BIT];
  endfunction

  // word 1 read completes on this edge
  assign word1_taken = (state_q == RDS_RD1) && i_mack;

  // flag qualification for the entry being closed
  always_comb
  begin
    // framing only on odd bits plus bad FCS, never in internal loopback
    framing_v = done_q.dribble & done_q.fcs_bad & done_q.last
                & ~done_q.fifo_overflow & ~i_loopback;
    // overflow hidden behind an earlier buffer error, shown when both arose together
    overflow_v = done_q.fifo_overflow & ~done_q.last
                 & (~buffer_err_q | buffer_with_overflow_q);
    crc_v = done_q.fcs_bad & done_q.last & ~done_q.fifo_overflow;
    sof_v = ~in_frame_q;
  end

  rds_status_fmt u_fmt (
    .i_word1_rd(word1_q),
    .i_sof(sof_v),
    .i_eof(done_q.last),
    .i_framing_error(framing_v),
    .i_overflow_error(overflow_v),
    .i_crc(crc_v),
    .i_buffer_error(buffer_err_q),
    .i_sof_by_driver(i_start_of_packet_irq_mode),
    .o_word1_wr(word1_wr)
  );

  // entry sequencing: fetch, fill, count write, then owner release
  always_comb
  begin
    state_d = state_q;
    case (state_q)
      RDS_IDLE:
      begin
        if (i_start)
        begin
          state_d = RDS_RD0;
        end
      end
      RDS_RD0:
      begin
        if (i_mack)
        begin
          state_d = RDS_RD1;
        end
      end
      RDS_RD1:
      begin
        // entry not ours: leave it untouched
        if (i_mack)
        begin
          state_d = ctrl_owns(i_mdata) ? RDS_FILL : RDS_IDLE;
        end
      end
      RDS_FILL:
      begin
        if (i_buf_done)
        begin
          state_d = RDS_WR3;
        end
      end
      RDS_WR3:
      begin
        if (i_mack)
        begin
          state_d = RDS_WR1;
        end
      end
      RDS_WR1:
      begin
        if (i_mack)
        begin
          state_d = RDS_IDLE;
        end
      end
      default:
      begin
        state_d = RDS_IDLE;
      end
    endcase
  end

  // state register
  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      state_q <= RDS_IDLE;
    end
    else if (i_ce)
    begin
      state_q <= state_d;
    end
  end

  // captured pointer words; any alignment and length is taken as is
  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      word0_q <= RDS_WORD_RST;
      word1_q <= RDS_WORD_RST;
    end
    else if (i_ce && i_mack)
    begin
      if (state_q == RDS_RD0)
      begin
        word0_q <= i_mdata;
      end
      if (state_q == RDS_RD1)
      begin
        word1_q <= i_mdata;
      end
    end
  end

  // end-of-buffer report held for the write-back
  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      done_q <= '0;
    end
    else if (i_ce && state_q == RDS_FILL && i_buf_done)
    begin
      done_q <= i_done;
    end
  end

  // frame chaining and buffer error tracking
  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      in_frame_q <= 1'b0;
      buffer_err_q <= 1'b0;
      buffer_with_overflow_q <= 1'b0;
    end
    else if (i_ce)
    begin
      if (word1_taken && !ctrl_owns(i_mdata) && in_frame_q)
      begin
        // chained entry still held by the host; a later overflow stays hidden
        buffer_err_q <= 1'b1;
      end
      else if (state_q == RDS_FILL && i_fifo_overflow && in_frame_q && i_buf_done)
      begin
        // overflow before the next poll; lost data reported now still shows
        buffer_err_q <= 1'b1;
        buffer_with_overflow_q <= i_done.fifo_overflow;
      end
      else if (state_q == RDS_WR1 && i_mack)
      begin
        in_frame_q <= ~done_q.last;
        buffer_err_q <= 1'b0;
        buffer_with_overflow_q <= 1'b0;
      end
    end
  end

  // memory requests: reads of words 0 and 1, writes of words 3 and 1;
  // a request waiting for its acknowledge is held exactly as issued
  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      o_mreq <= '0;
    end
    else if (i_ce)
    begin
      if (o_mreq.valid && !i_mack)
      begin
        o_mreq <= o_mreq;
      end
      else
      begin
        case (state_d)
          RDS_RD0:
          begin
            o_mreq <= '{valid: 1'b1, write: 1'b0, word: RDS_W0, data: RDS_WORD_RST};
          end
          RDS_RD1:
          begin
            o_mreq <= '{valid: 1'b1, write: 1'b0, word: RDS_W1, data: RDS_WORD_RST};
          end
          RDS_WR3:
          begin
            // only entered on the buffer-done edge, where the report is valid
            o_mreq <= '{valid: 1'b1, write: 1'b1, word: RDS_W3,
                        data: {4'h0, i_done.count}};
          end
          RDS_WR1:
          begin
            o_mreq <= '{valid: 1'b1, write: 1'b1, word: RDS_W1, data: word1_wr};
          end
          default:
          begin
            o_mreq <= '0;
          end
        endcase
      end
    end
  end

  // user-side status outputs
  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      o_buf_addr <= 24'h000000;
      o_fill_en <= 1'b0;
      o_busy <= 1'b0;
      o_not_owned <= 1'b0;
      o_entry_done <= 1'b0;
    end
    else if (i_ce)
    begin
      // address stands from the first fill cycle on
      if (word1_taken)
      begin
        o_buf_addr <= buf_addr(word0_q, i_mdata);
      end
      else
      begin
        o_buf_addr <= buf_addr(word0_q, word1_q);
      end
      o_fill_en <= (state_d == RDS_FILL);
      o_busy <= (state_d != RDS_IDLE);
      o_not_owned <= word1_taken && !ctrl_owns(i_mdata);
      o_entry_done <= (state_q == RDS_WR1) && i_mack;
    end
  end
endmodule

/* File: rtl/rds_status_fmt.sv */
// Purpose: builds the status word 1 written back into a receive entry
// Assumes: inputs stable while the write is formed
// Notes: high address bits are copied unchanged from the read image
module rds_status_fmt
  import rds_pkg::*;
(
  input wire logic [15:0] i_word1_rd,
  input wire logic i_sof,
  input wire logic i_eof,
  input wire logic i_framing_error,
  input wire logic i_overflow_error,
  input wire logic i_crc,
  input wire logic i_buffer_error,
  input wire logic i_sof_by_driver,
  output logic [15:0] o_word1_wr
);
  import rds_pkg::*;

  // owner flag cleared, error summary formed, address bits kept
  always_comb
  begin
    o_word1_wr = RDS_WORD_RST;
    o_word1_wr[RDS_OWN_BIT] = 1'b0;
    o_word1_wr[RDS_ERR_BIT] = i_framing_error | i_overflow_error
                              | i_crc | i_buffer_error;
    o_word1_wr[RDS_FRAMING_BIT] = i_framing_error;
    o_word1_wr[RDS_OVERFLOW_BIT] = i_overflow_error;
    o_word1_wr[RDS_CRC_BIT] = i_crc;
    o_word1_wr[RDS_BUFFER_BIT] = i_buffer_error;
    // driver owns the start flag in start-of-packet interrupt mode
    o_word1_wr[RDS_SOF_BIT] = i_sof_by_driver ? i_word1_rd[RDS_SOF_BIT] : i_sof;
    o_word1_wr[RDS_EOF_BIT] = i_eof;
    o_word1_wr[RDS_ADDR_HIGH_MSB:0] = i_word1_rd[RDS_ADDR_HIGH_MSB:0];
  end
endmodule

/* File: testbench/rds_host_mem.sv */
// Purpose: host memory holding one receive entry
// Assumes: requests hold until acknowledged
// Notes: answers after i_lat idle cycles
module rds_host_mem
  import rds_pkg::*;
(
  input wire logic i_clk,
  input wire rds_pkg::rds_mreq_s i_req,
  input wire logic [3:0] i_lat,
  output logic o_mack,
  output logic [15:0] o_mdata
);
  timeunit 1ns / 1ps;
  logic [15:0] mem [4]; // four words per entry
  logic [3:0] wait_q = 4'h0;
  initial o_mack = 1'b0;
  initial o_mdata = 16'h0000;
  // one-cycle acknowledge; idle data line toggles
  always @(negedge i_clk)
  begin
    if (o_mack || !i_req.valid)
    begin
      o_mack <= 1'b0;
      wait_q <= 4'h0;
      o_mdata <= ~o_mdata;
    end
    else if (wait_q < i_lat)
      wait_q <= wait_q + 4'h1;
    else
    begin
      o_mack <= 1'b1;
      o_mdata <= i_req.write ? ~o_mdata : mem[i_req.word];
    end
  end
  // writes land on the acknowledged edge
  always @(posedge i_clk)
  begin
    if (o_mack && i_req.valid && i_req.write)
      mem[i_req.word] <= i_req.data;
  end
endmodule

/* File: testbench/rds_rx_entry_properties.sv */
// Purpose: port checks for the receive entry walker
// Assumes: one clock domain, async active-low reset
// Notes: bound onto rds_rx_entry below
module rds_rx_entry_properties
  import rds_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic i_ce,
  input wire logic i_start,
  input wire logic i_loopback,
  input wire logic i_mack,
  input wire rds_pkg::rds_mreq_s o_mreq,
  input wire logic o_busy
);
  timeunit 1ns / 1ps;
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rstn);
  // status and count write-back requests
  wire logic wr1 = o_mreq.valid && o_mreq.write && o_mreq.word == RDS_W1;
  wire logic wr3 = o_mreq.valid && o_mreq.write && o_mreq.word == RDS_W3;
  err_or_a: assert property (
    wr1 |-> o_mreq.data[RDS_ERR_BIT] == |o_mreq.data[13:10])
    else $error("error bit wrong");
  own_clear_a: assert property (
    wr1 |-> !o_mreq.data[RDS_OWN_BIT]) else $error("owner kept");
  count_top_a: assert property (
    wr3 |-> o_mreq.data[15:12] == 4'h0) else $error("count top set");
  req_hold_a: assert property (
    o_mreq.valid && !i_mack |=> $stable(o_mreq)) else $error("request moved");
  framing_loop_a: assert property (
    wr1 && i_loopback |-> !o_mreq.data[RDS_FRAMING_BIT]) else $error("framing in loop");
  framing_fcs_a: assert property (
    wr1 && o_mreq.data[RDS_FRAMING_BIT] |-> o_mreq.data[RDS_CRC_BIT])
    else $error("framing without fcs");
  overflow_end_a: assert property (
    wr1 && o_mreq.data[RDS_OVERFLOW_BIT] |-> !o_mreq.data[RDS_EOF_BIT])
    else $error("overflow with end");
  start_read_a: assert property (
    i_start && i_ce && !o_busy |=> o_mreq.valid && !o_mreq.write && o_mreq.word == RDS_W0)
    else $error("no word 0 read");
  // main scenarios
  cover property (wr1 && o_mreq.data[RDS_FRAMING_BIT]);
  cover property (wr1 && !o_mreq.data[RDS_SOF_BIT]);
  cover property (wr1 && i_loopback);
  cover property (wr1 && o_mreq.data[RDS_BUFFER_BIT] && o_mreq.data[RDS_OVERFLOW_BIT]);
endmodule

bind rds_rx_entry rds_rx_entry_properties u_props (.i_clk(i_clk), .i_rstn(i_rstn),
  .i_ce(i_ce), .i_start(i_start), .i_loopback(i_loopback), .i_mack(i_mack),
  .o_mreq(o_mreq), .o_busy(o_busy));

/* File: testbench/test_rx_descriptor_status.sv */
// Purpose: walks receive entries through the block and checks write-back
// Assumes: inputs change at falling edges
// Notes: overflow input raised for one chained entry only
module test_rx_descriptor_status;
  import rds_pkg::*;
  timeunit 1ns / 1ps;
  logic clk = 0, rst_n = 0, start = 0, loop = 0, sop = 0, buf_done = 0, fifo_over = 0;
  logic mack, fill, busy, nown, edone;
  logic [15:0] mdata;
  logic [23:0] addr;
  logic [3:0] lat = 4'h0;
  rds_done_s done = '0;
  rds_mreq_s mreq;
  int err_count = 0, tests_run = 0;
  rds_rx_entry u_dut (.i_clk(clk), .i_rstn(rst_n), .i_ce(1'b1), .i_start(start),
    .i_loopback(loop), .i_start_of_packet_irq_mode(sop), .i_mack(mack), .i_mdata(mdata),
    .i_buf_done(buf_done), .i_done(done), .i_fifo_overflow(fifo_over), .o_mreq(mreq),
    .o_buf_addr(addr), .o_fill_en(fill), .o_busy(busy), .o_not_owned(nown),
    .o_entry_done(edone));
  rds_host_mem u_mem (.i_clk(clk), .i_req(mreq), .i_lat(lat), .o_mack(mack), .o_mdata(mdata));
  // compare and count
  task automatic check(string name, logic [23:0] seen, logic [23:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      err_count++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic conclude;
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  function automatic rds_done_s dn(logic l, logic dr, logic f, logic [11:0] c);
    dn = '{l, dr, f, 1'b0, c};
  endfunction
  // one entry: fetch, fill if owned, then write-back checks
  task automatic walk(input logic [15:0] w1, input rds_done_s d, input logic [15:0] e1);
    int n;
    n = 0;
    u_mem.mem = '{16'h1235, w1, 16'hffc0, 16'h0000};
    @(negedge clk);
    start = 1;
    @(negedge clk);
    start = 0;
    while (fill !== 1'b1 && nown !== 1'b1 && n < 60)
    begin
      @(negedge clk);
      n++;
    end
    if (w1[15])
    begin
      check("fill", fill, 1'b1);
      check("addr", addr, {w1[7:0], 16'h1235});
      done = d;
      buf_done = 1;
      @(negedge clk);
      buf_done = 0;
    end
    else
      check("not_owned", nown, 1'b1);
    n = 0;
    while (busy === 1'b1 && n < 60)
    begin
      @(negedge clk);
      n++;
    end
    check("idle", busy, 1'b0);
    check("entry_done", edone, w1[15]);
    check("word1", u_mem.mem[1], e1);
    check("word3", u_mem.mem[3], w1[15] ? {4'h0, d.count} : 16'h0000);
    check("word2", u_mem.mem[2], 16'hffc0);
  endtask
  initial forever #2 clk = ~clk;
  // watchdog
  initial
  begin
    #20000;
    err_count++;
    conclude;
  end
  initial
  begin
    repeat (2) @(negedge clk);
    rst_n = 1;
    walk(16'h805a, dn(1, 0, 0, 12'h03c), 16'h035a);
    lat = 4'h3;
    walk(16'h805a, dn(1, 1, 1, 12'h041), 16'h6b5a);
    walk(16'h805a, dn(1, 1, 0, 12'h041), 16'h035a);
    loop = 1;
    walk(16'h805a, dn(1, 1, 1, 12'h7ff), 16'h4b5a);
    loop = 0;
    lat = 4'h0;
    walk(16'h80a5, dn(0, 0, 0, 12'h100), 16'h02a5);
    walk(16'h80a5, dn(1, 0, 0, 12'h200), 16'h01a5);
    walk(16'h005a, dn(1, 0, 0, 12'h000), 16'h005a);
    sop = 1;
    walk(16'h805a, dn(1, 0, 0, 12'h010), 16'h015a);
    sop = 0;
    walk(16'h805a, '{1'b0, 1'b0, 1'b0, 1'b1, 12'h020}, 16'h525a);
    walk(16'h005a, dn(1, 0, 0, 12'h000), 16'h005a);
    walk(16'h805a, '{1'b0, 1'b0, 1'b0, 1'b1, 12'h030}, 16'h445a);
    fifo_over = 1;
    walk(16'h805a, '{1'b0, 1'b0, 1'b0, 1'b1, 12'h040}, 16'h545a);
    fifo_over = 0;
    walk(16'h805a, dn(1, 0, 0, 12'h050), 16'h015a);
    conclude;
  end
endmodule
